// ### rtl/traction_pkg.sv
// Shared constants for traction braking and input scaling
// How it works
// - Direction change brakes at programmed percentage
// - Neutral brakes at programmed neutral percentage
// - Full pedal brakes at pedal percentage
// - Speed mode ignores regen strength settings
// - Torque mode ramps to direction braking
// - Speed mode ramps to zero, then accelerates
// - Torque mode ramps to neutral braking
// - Speed mode neutral ramps speed to zero
// - Footbrake ramps over pedal ramp time
// - Hold zero speed after neutral/pedal ramp
// - Instant reversal only at or below sweep threshold
// - Current demand clamped to programmed limit
// - Gauge decrements when battery at/below nominal
// - Steer pump held after trigger removed
// - Park brake applied after standstill delay
// - Park brake released 0.1s after pulsing
// - Throttle scaled between zero and full volts
// - Setup 2 maps throttle reverse to forward
// - Pedal scaled from zero to pedal force
// - Steer pot ignored when motor select 0
// - Steer center voltage means no steering
// - Wig-wag forward above forward threshold, deadband
// - Wig-wag reverse past reverse threshold
package traction_pkg;
  // -----------------------------------------------------------------
  // Timing
  // -----------------------------------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int RELEASE_MS = 100;
  localparam int RELEASE_TICKS = RELEASE_MS / TICK_MS;
  // -----------------------------------------------------------------
  // Field widths and ranges
  // -----------------------------------------------------------------
  localparam int PCT_W = 7;
  localparam logic [6:0] PCT_MAX = 7'h64;
  localparam int TIME_W = 9;
  localparam logic [8:0] RAMP_MIN = 9'h001;
  localparam int VOLT_W = 6;
  localparam logic [5:0] VOLT_MAX = 6'h32;
  localparam int DEM_W = 8;
  localparam logic [7:0] DEM_FULL = 8'hFF;
  localparam logic [1:0] SETUP_WIGWAG = 2'h2;
  localparam logic [1:0] MSEL_SINGLE = 2'h0;
  localparam int AMP_W = 10;
  localparam int FREQ_W = 12;
  localparam int BAT_W = 8;
endpackage : traction_pkg

// ### rtl/tick_timer.sv
// Tenth-second countdown timer driven by a shared tick
`timescale 1ns/100ps
module tick_timer #(
  parameter int W = 9
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control
  input wire logic tick,
  input wire logic load,
  input wire logic [W-1:0] count,
  // Status
  output logic busy,
  output logic done
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic run;
    logic fin;
  } tmr_s;
  tmr_s q, d;

  // Load restarts; counting only on ticks so resolution is 0.1s
  always_comb begin
    d = q;
    d.fin = 1'b0;
    if (load) begin
      d.cnt = count;
      d.run = (count != '0);
      d.fin = (count == '0);
    end else if (q.run && tick) begin
      d.cnt = q.cnt - 1'b1;
      if (q.cnt == {{(W-1){1'b0}}, 1'b1}) begin
        d.run = 1'b0;
        d.fin = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign busy = q.run;
  assign done = q.fin;

  a_timer_ends: assert property (@(posedge clk)
    disable iff (!resetn) q.run && !load && tick && q.cnt == 1 |=>
    done && !busy)
    else $error("timer did not finish");
endmodule : tick_timer

// ### rtl/input_scaler.sv
// Linear mapping of a pot voltage onto a demand span
`timescale 1ns/100ps
module input_scaler #(
  parameter int VW = 6,
  parameter int OW = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Calibration and sample
  input wire logic [VW-1:0] lo_v,
  input wire logic [VW-1:0] hi_v,
  input wire logic [VW-1:0] in_v,
  // Result, 0 at lo_v, full at hi_v
  output logic [OW-1:0] level
);
  typedef struct packed {
    logic [OW-1:0] lvl;
  } sc_s;
  sc_s q, d;
  logic [VW-1:0] span;
  logic [VW-1:0] off;
  logic [VW+OW-1:0] prod;

  // Clamp outside the window; a reversed window reads as zero
  always_comb begin
    d = q;
    span = hi_v - lo_v;
    off = in_v - lo_v;
    prod = (VW+OW)'(off) * (VW+OW)'({OW{1'b1}});
    if (hi_v <= lo_v || in_v <= lo_v) begin
      d.lvl = '0;
    end else if (in_v >= hi_v) begin
      d.lvl = {OW{1'b1}};
    end else begin
      d.lvl = OW'(prod / (VW+OW)'(span));
    end
  end

  // Output register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level = q.lvl;
endmodule : input_scaler

// ### rtl/traction_brake.sv
// Braking demand, hold timing and input scaling for a traction drive
`timescale 1ns/100ps
module traction_brake #(
  parameter int TICK_CYCLES = traction_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Programmed strengths, percent
  input wire logic [6:0] direction_regen_strength,
  input wire logic [6:0] neutral_regen_strength,
  input wire logic [6:0] pedal_regen_strength,
  // Programmed times, tenths of a second
  input wire logic [8:0] direction_brake_ramp_time,
  input wire logic [8:0] neutral_brake_ramp_time,
  input wire logic [8:0] pedal_brake_ramp_time,
  input wire logic [8:0] hill_hold_time,
  input wire logic [8:0] steer_pump_hold_time,
  input wire logic [8:0] park_brake_apply_delay,
  // Limits, sixteenths of Hz, amps, volts
  input wire logic [6:0] instant_reversal_threshold,
  input wire logic [9:0] current_limit,
  input wire logic [7:0] nominal_battery_level,
  // Calibration voltages, tenths of a volt
  input wire logic [5:0] throttle_zero_voltage,
  input wire logic [5:0] throttle_full_voltage,
  input wire logic [5:0] pedal_zero_voltage,
  input wire logic [5:0] pedal_full_voltage,
  input wire logic [5:0] steer_left_lock_voltage,
  input wire logic [5:0] steer_center_voltage,
  input wire logic [5:0] steer_right_lock_voltage,
  input wire logic [5:0] forward_start_voltage,
  input wire logic [5:0] reverse_start_voltage,
  // Configuration
  input wire logic speed_mode,
  input wire logic [1:0] analog_setup,
  input wire logic [1:0] motor_select,
  // Vehicle inputs
  input wire logic fwd_sw,
  input wire logic rev_sw,
  input wire logic [5:0] throttle_v,
  input wire logic [5:0] pedal_v,
  input wire logic [5:0] steer_v,
  input wire logic [11:0] stator_freq,
  input wire logic [9:0] current_demand,
  input wire logic [7:0] battery_v,
  input wire logic steer_trigger,
  input wire logic standstill,
  input wire logic pulsing,
  // Demand outputs
  output logic [7:0] throttle_level,
  output logic throttle_fwd,
  output logic throttle_rev,
  output logic [7:0] pedal_level,
  output logic [6:0] brake_strength,
  output logic [7:0] ramp_level,
  output logic speed_to_zero,
  output logic accel_normal,
  output logic zero_hold,
  output logic instant_reversal_ok,
  output logic [9:0] current_cmd,
  output logic [6:0] steer_angle,
  output logic steer_left,
  // Vehicle outputs
  output logic battery_charge_gauge,
  output logic steer_pump_on,
  output logic park_brake_on
);
  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_DRIVE = 4'h1,
    ST_RAMP = 4'h2,
    ST_HOLD = 4'h4,
    ST_IDLE = 4'h8
  } brk_e;
  typedef enum logic [1:0] {
    SRC_DIR = 2'h0,
    SRC_NEU = 2'h1,
    SRC_PED = 2'h2
  } src_e;
  typedef struct packed {
    brk_e st;
    src_e src;
    logic [23:0] div;
    logic tick;
    logic [1:0] dir;
    logic [8:0] ramp_len;
    logic [8:0] ramp_cnt;
    logic [7:0] ramp;
    logic [6:0] strength;
    logic [9:0] icmd;
    logic [7:0] tlvl;
    logic tfwd;
    logic trev;
    logic [6:0] sang;
    logic sleft;
    logic gauge;
    logic brake;
    logic [1:0] rel_cnt;
    logic pulsing_q;
    logic trig_q;
    logic still_q;
    logic accel;
  } core_s;
  core_s q, d;

  logic [7:0] thr_lvl;
  logic [7:0] ped_lvl;
  logic pump_busy;
  logic pump_load;
  logic hold_busy;
  logic hold_done;
  logic hold_load;
  logic park_done;
  logic park_load;
  logic [1:0] want_dir;
  logic ped_on;
  logic wig;
  logic [5:0] s_span;
  logic [13:0] s_prod;

  // -----------------------------------------------------------------
  // Input scaling
  // -----------------------------------------------------------------
  input_scaler #(.VW(6), .OW(8)) u_thr (
    .clk(clk), .resetn(resetn),
    .lo_v(throttle_zero_voltage), .hi_v(throttle_full_voltage),
    .in_v(throttle_v), .level(thr_lvl)
  );
  input_scaler #(.VW(6), .OW(8)) u_ped (
    .clk(clk), .resetn(resetn),
    .lo_v(pedal_zero_voltage), .hi_v(pedal_full_voltage),
    .in_v(pedal_v), .level(ped_lvl)
  );

  // Timers share the tenth-second tick
  tick_timer #(.W(9)) u_hold (
    .clk(clk), .resetn(resetn), .tick(q.tick), .load(hold_load),
    .count(hill_hold_time), .busy(hold_busy), .done(hold_done)
  );
  tick_timer #(.W(9)) u_pump (
    .clk(clk), .resetn(resetn), .tick(q.tick), .load(pump_load),
    .count(steer_pump_hold_time), .busy(pump_busy), .done()
  );
  tick_timer #(.W(9)) u_park (
    .clk(clk), .resetn(resetn), .tick(q.tick), .load(park_load),
    .count(park_brake_apply_delay), .busy(), .done(park_done)
  );

  // Decode wanted direction; wig-wag has a neutral deadband
  always_comb begin
    wig = (analog_setup == traction_pkg::SETUP_WIGWAG);
    want_dir = {rev_sw, fwd_sw};
    if (wig) begin
      want_dir = 2'b00;
      if (throttle_v > forward_start_voltage) begin
        want_dir = 2'b01;
      end else if (throttle_v < reverse_start_voltage) begin
        want_dir = 2'b10;
      end
    end
    if (want_dir == 2'b11) begin
      want_dir = 2'b00;
    end
    ped_on = (ped_lvl != 8'h00);
  end

  // Trigger loads for the three timers
  assign pump_load = q.trig_q && !steer_trigger;
  assign park_load = standstill && !q.still_q;
  assign hold_load = (q.st == ST_RAMP) && (q.ramp_cnt == 9'h000) &&
    (q.src != SRC_DIR) && q.tick;

  // -----------------------------------------------------------------
  // Main next-state logic
  // -----------------------------------------------------------------
  always_comb begin
    d = q;
    s_span = '0;
    s_prod = '0;
    d.tick = 1'b0;
    d.div = q.div + 24'h000001;
    if (q.div == 24'(TICK_CYCLES - 1)) begin
      d.div = '0;
      d.tick = 1'b1;
    end
    d.pulsing_q = pulsing;
    d.trig_q = steer_trigger;
    d.still_q = standstill;
    d.accel = 1'b0;
    // Start a braking ramp on reversal, neutral entry or pedal
    if (want_dir != q.dir && q.dir != 2'b00 && want_dir != 2'b00 &&
        stator_freq > 12'(instant_reversal_threshold)) begin
      d.st = ST_RAMP;
      d.src = SRC_DIR;
      d.ramp_len = direction_brake_ramp_time;
      d.ramp_cnt = direction_brake_ramp_time;
      d.strength = direction_regen_strength;
    end else if (ped_on && q.src != SRC_PED) begin
      d.st = ST_RAMP;
      d.src = SRC_PED;
      d.ramp_len = pedal_brake_ramp_time;
      d.ramp_cnt = pedal_brake_ramp_time;
      d.strength = pedal_regen_strength;
    end else if (want_dir == 2'b00 && q.dir != 2'b00 && !ped_on) begin
      d.st = ST_RAMP;
      d.src = SRC_NEU;
      d.ramp_len = neutral_brake_ramp_time;
      d.ramp_cnt = neutral_brake_ramp_time;
      d.strength = neutral_regen_strength;
    end else begin
      case (q.st)
        ST_RAMP: begin
          if (q.tick && q.ramp_cnt != 9'h000) begin
            d.ramp_cnt = q.ramp_cnt - 9'h001;
          end
          if (q.ramp_cnt == 9'h000) begin
            if (q.src == SRC_DIR) begin
              d.st = ST_DRIVE;
              d.accel = 1'b1;
            end else if (q.tick) begin
              d.st = ST_HOLD;
            end
          end
        end
        ST_HOLD: begin
          if (hold_done || (!hold_busy && !hold_load)) begin
            d.st = ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (want_dir != 2'b00 && !ped_on) begin
            d.st = ST_DRIVE;
            d.src = SRC_DIR;
          end
        end
        ST_DRIVE: begin
          if (!ped_on && q.src == SRC_PED) begin
            d.src = SRC_DIR;
          end
        end
        default: begin
          d.st = ST_DRIVE;
        end
      endcase
    end
    d.dir = want_dir;
    // Re-arm the pedal once released, but let a running ramp finish
    if (!ped_on && q.src == SRC_PED && d.st != ST_RAMP) begin
      d.src = SRC_DIR;
    end
    // Ramp fraction, 0 at start to full at end
    if (q.st == ST_RAMP && q.ramp_len >= traction_pkg::RAMP_MIN) begin
      d.ramp = 8'((17'(q.ramp_len - q.ramp_cnt) * 17'h000FF) /
        17'(q.ramp_len));
    end else if (q.st == ST_RAMP) begin
      d.ramp = traction_pkg::DEM_FULL;
    end else if (q.st == ST_DRIVE) begin
      d.ramp = '0;
    end
    // Clamp the current command
    d.icmd = (current_demand > current_limit) ? current_limit :
      current_demand;
    // Throttle: signed magnitude in setup 2; flags keep the deadband
    d.tlvl = thr_lvl;
    d.tfwd = (want_dir == 2'b01);
    d.trev = (want_dir == 2'b10);
    if (wig || analog_setup == traction_pkg::SETUP_WIGWAG) begin
      d.tlvl = thr_lvl[7] ? 8'({thr_lvl[6:0], 1'b1}) :
        8'({~thr_lvl[6:0], 1'b1});
    end
    // Steering angle against centre
    d.sang = '0;
    d.sleft = 1'b0;
    if (motor_select != traction_pkg::MSEL_SINGLE) begin
      if (steer_v < steer_center_voltage) begin
        s_span = steer_center_voltage - steer_left_lock_voltage;
        s_prod = 14'(steer_center_voltage - steer_v) * 14'h0064;
        d.sleft = 1'b1;
      end else begin
        s_span = steer_right_lock_voltage - steer_center_voltage;
        s_prod = 14'(steer_v - steer_center_voltage) * 14'h0064;
      end
      if (s_span != 6'h00) begin
        d.sang = 7'(s_prod / 14'(s_span));
      end
      if (d.sang > traction_pkg::PCT_MAX) begin
        d.sang = traction_pkg::PCT_MAX;
      end
    end
    d.gauge = (battery_v <= nominal_battery_level);
    // Park brake release after fixed delay, apply after standstill
    if (pulsing && !q.pulsing_q) begin
      d.rel_cnt = 2'(traction_pkg::RELEASE_TICKS);
    end else if (q.tick && q.rel_cnt != 2'h0 && pulsing) begin
      d.rel_cnt = q.rel_cnt - 2'h1;
      if (q.rel_cnt == 2'h1) begin
        d.brake = 1'b0;
      end
    end
    if (park_done && standstill && !pulsing) begin
      d.brake = 1'b1;
    end
  end

  // State register; brake engaged from reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.brake <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  assign throttle_level = q.tlvl;
  assign throttle_fwd = q.tfwd;
  assign throttle_rev = q.trev;
  assign pedal_level = ped_lvl;
  // Speed mode drops strength settings, only ramps speed
  assign brake_strength = speed_mode ? 7'h00 : q.strength;
  assign ramp_level = q.ramp;
  assign speed_to_zero = speed_mode && (q.st == ST_RAMP);
  assign accel_normal = q.accel;
  assign zero_hold = (q.st == ST_HOLD);
  assign instant_reversal_ok =
    (stator_freq <= 12'(instant_reversal_threshold));
  assign current_cmd = q.icmd;
  assign steer_angle = q.sang;
  assign steer_left = q.sleft;
  assign battery_charge_gauge = q.gauge;
  // Last trigger cycle bridges the gap until the hold timer loads
  assign steer_pump_on = steer_trigger || q.trig_q || pump_busy;
  assign park_brake_on = q.brake;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  a_current_clamp: assert property (@(posedge clk)
    disable iff (!resetn) ##1 current_cmd <= $past(current_limit))
    else $error("current above limit");
  a_speed_strength: assert property (@(posedge clk)
    disable iff (!resetn) speed_mode |-> brake_strength == 7'h00)
    else $error("strength used in speed mode");
  a_gauge_level: assert property (@(posedge clk)
    disable iff (!resetn)
    battery_v <= nominal_battery_level |=> battery_charge_gauge)
    else $error("gauge not decrementing");
  a_pump_hold: assert property (@(posedge clk)
    disable iff (!resetn)
    $fell(steer_trigger) && steer_pump_hold_time != 0 |->
    steer_pump_on ##1 steer_pump_on)
    else $error("pump dropped early");
  a_steer_single: assert property (@(posedge clk)
    disable iff (!resetn) motor_select == 2'h0 |=> steer_angle == 7'h00)
    else $error("steer used in single motor");
  a_tick_period: assert property (@(posedge clk)
    disable iff (!resetn) q.tick |=> !q.tick)
    else $error("tick too long");
  a_hold_follows: assert property (@(posedge clk)
    disable iff (!resetn) hold_load |=> zero_hold)
    else $error("hold not entered");
  a_reversal_ramp: assert property (@(posedge clk)
    disable iff (!resetn) want_dir != q.dir && q.dir != 2'b00 &&
    want_dir != 2'b00 && !instant_reversal_ok |=> q.st == ST_RAMP)
    else $error("slow reversal did not ramp");
  c_ramp_seen: cover property (@(posedge clk) q.st == ST_RAMP);
  c_hold_seen: cover property (@(posedge clk) zero_hold);
  c_brake_off: cover property (@(posedge clk) $fell(park_brake_on));
  c_pump_tail: cover property (@(posedge clk)
    !steer_trigger && steer_pump_on);
endmodule : traction_brake

// ### verif/vehicle_model.sv
// Vehicle side model: pots, direction switches and motor state
`timescale 1ns/100ps
module vehicle_model (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Bench commands: pots, and switches {fwd, rev, trigger, pulse, stop}
  input wire logic [5:0] cmd_throttle,
  input wire logic [5:0] cmd_pedal,
  input wire logic [5:0] cmd_steer,
  input wire logic [4:0] cmd_sw,
  // Lines seen by the controller
  output logic [5:0] throttle_v,
  output logic [5:0] pedal_v,
  output logic [5:0] steer_v,
  output logic fwd_sw,
  output logic rev_sw,
  output logic steer_trigger,
  output logic pulsing,
  output logic standstill
);
  // Pots and switches settle one clock after a command
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {throttle_v, pedal_v, steer_v} <= '0;
      {fwd_sw, rev_sw, steer_trigger, pulsing} <= '0;
      standstill <= 1'b0;
    end else begin
      throttle_v <= cmd_throttle;
      pedal_v <= cmd_pedal;
      steer_v <= cmd_steer;
      {fwd_sw, rev_sw, steer_trigger, pulsing} <= cmd_sw[4:1];
      // A pulsing motor is never reported at standstill
      standstill <= cmd_sw[0] & ~cmd_sw[1];
    end
  end
endmodule : vehicle_model

// ### verif/test_traction_brake.sv
// Self-checking bench for the traction braking block
`timescale 1ns/100ps
module test_traction_brake;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [6:0] direction_regen_strength, neutral_regen_strength;
  logic [6:0] pedal_regen_strength, instant_reversal_threshold;
  logic [8:0] direction_brake_ramp_time, neutral_brake_ramp_time;
  logic [8:0] pedal_brake_ramp_time, hill_hold_time;
  logic [8:0] steer_pump_hold_time, park_brake_apply_delay;
  logic [9:0] current_limit, current_demand, current_cmd;
  logic [7:0] nominal_battery_level, battery_v;
  logic [5:0] throttle_zero_voltage, throttle_full_voltage;
  logic [5:0] pedal_zero_voltage, pedal_full_voltage;
  logic [5:0] steer_left_lock_voltage, steer_center_voltage;
  logic [5:0] steer_right_lock_voltage, forward_start_voltage;
  logic [5:0] reverse_start_voltage, throttle_v, pedal_v, steer_v;
  logic [5:0] cmd_throttle, cmd_pedal, cmd_steer;
  logic [4:0] cmd_sw;
  logic [1:0] analog_setup, motor_select;
  logic [11:0] stator_freq;
  logic speed_mode, fwd_sw, rev_sw, steer_trigger, standstill, pulsing;
  logic [7:0] throttle_level, pedal_level, ramp_level;
  logic [6:0] brake_strength, steer_angle;
  logic throttle_fwd, throttle_rev, speed_to_zero, accel_normal;
  logic zero_hold, instant_reversal_ok, steer_left;
  logic battery_charge_gauge, steer_pump_on, park_brake_on;
  typedef struct {logic [3:0] sel; logic [9:0] val;} note_s;
  note_s notes[$];
  note_s note;
  logic look = 1'b0;
  logic [31:0] rng = 32'h00000839;
  int mismatches = 0;
  int checked = 0;

  // Short tick keeps every timer within a few hundred cycles
  traction_brake #(.TICK_CYCLES(20)) dut_u (.*);
  vehicle_model model_u (.*);

  always #25 clk = ~clk;

  // ---------------------------------------------------------------
  // Checking
  // ---------------------------------------------------------------
  function automatic logic [9:0] seen(input logic [3:0] s);
    case (s)
      4'h0: seen = {2'h0, throttle_level};
      4'h1: seen = {8'h00, throttle_fwd, throttle_rev};
      4'h2: seen = {2'h0, pedal_level};
      4'h3: seen = {3'h0, brake_strength};
      4'h4: seen = current_cmd;
      4'h5: seen = {9'h000, battery_charge_gauge};
      4'h6: seen = {9'h000, instant_reversal_ok};
      4'h7: seen = {2'h0, steer_left, steer_angle};
      4'h8: seen = {9'h000, steer_pump_on};
      4'h9: seen = {9'h000, park_brake_on};
      4'hB: seen = {2'h0, ramp_level};
      4'hC: seen = {9'h000, speed_to_zero};
      default: seen = {9'h000, zero_hold};
    endcase
  endfunction : seen

  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask : check

  // Drain every pending note while the outputs are settled
  always @(posedge clk) begin
    if (look) begin
      while (notes.size() > 0) begin
        note = notes.pop_front();
        check(seen(note.sel), note.val);
      end
    end
  end

  task automatic expect_out(input logic [3:0] s, input logic [9:0] v);
    notes.push_back('{s, v});
  endtask : expect_out

  task automatic observe();
    @(posedge clk);
    look <= 1'b1;
    @(posedge clk);
    look <= 1'b0;
  endtask : observe

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_cyc

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  task automatic end_of_test();
    $display("checked %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    wait_cyc(20000);
    mismatches++;
    end_of_test();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {direction_regen_strength, neutral_regen_strength} = 14'h1450;
    {pedal_regen_strength, instant_reversal_threshold} = 14'h1010;
    {direction_brake_ramp_time, neutral_brake_ramp_time} = 18'h00802;
    pedal_brake_ramp_time = 9'h002;
    hill_hold_time = 9'h003;
    steer_pump_hold_time = 9'h003;
    park_brake_apply_delay = 9'h002;
    {current_limit, current_demand, nominal_battery_level} = '0;
    battery_v = 8'h30;
    {throttle_zero_voltage, throttle_full_voltage} = 12'h2A8;
    {pedal_zero_voltage, pedal_full_voltage} = 12'h16D;
    {steer_left_lock_voltage, steer_center_voltage} = 12'h159;
    {steer_right_lock_voltage, forward_start_voltage} = 12'hB5E;
    reverse_start_voltage = 6'h14;
    {cmd_throttle, cmd_pedal, cmd_steer, cmd_sw} = '0;
    {analog_setup, motor_select, speed_mode} = '0;
    stator_freq = 12'h020;
    // Park brake is held on and demand idle while in reset
    expect_out(4'h9, 10'h001);
    expect_out(4'h4, 10'h000);
    observe();
    resetn <= 1'b1;
    // Random demands against random limits
    repeat (8) begin
      rng = xs(rng);
      current_limit <= rng[9:0];
      current_demand <= rng[25:16];
      wait_cyc(3);
      expect_out(4'h4, (rng[25:16] < rng[9:0]) ? rng[25:16] : rng[9:0]);
      observe();
    end
    // Gauge trigger at, below and just above nominal
    nominal_battery_level <= 8'h30;
    for (int i = -1; i < 2; i++) begin
      battery_v <= 8'(8'h30 + i);
      wait_cyc(3);
      expect_out(4'h5, {9'h000, i < 1});
      observe();
    end
    // Instant reversal boundary: at threshold and one step above
    for (int i = 0; i < 2; i++) begin
      stator_freq <= 12'(12'h010 + i);
      wait_cyc(3);
      expect_out(4'h6, {9'h000, i == 0});
      observe();
    end
    stator_freq <= 12'h000;
    // Throttle and pedal end points map to zero and full
    for (int i = 0; i < 2; i++) begin
      cmd_throttle <= i ? 6'h28 : 6'h0A;
      cmd_pedal <= i ? 6'h2D : 6'h05;
      wait_cyc(5);
      expect_out(4'h0, i ? 10'h0FF : 10'h000);
      expect_out(4'h2, i ? 10'h0FF : 10'h000);
      observe();
    end
    cmd_pedal <= 6'h05;
    // Wig-wag: above forward, deadband, below reverse
    analog_setup <= 2'h2;
    for (int i = 0; i < 3; i++) begin
      cmd_throttle <= (i == 0) ? 6'h28 : ((i == 1) ? 6'h19 : 6'h0A);
      wait_cyc(5);
      expect_out(4'h1, (i == 0) ? 10'h002 : ((i == 1) ? 10'h000 : 10'h001));
      if (i != 1) begin
        expect_out(4'h0, 10'h0FF);
      end
      observe();
    end
    analog_setup <= 2'h0;
    // Steering pot ignored in single motor, scaled in dual
    cmd_steer <= 6'h05;
    wait_cyc(5);
    expect_out(4'h7, 10'h000);
    observe();
    motor_select <= 2'h1;
    wait_cyc(5);
    expect_out(4'h7, 10'h0E4);
    observe();
    cmd_steer <= 6'h2D;
    wait_cyc(5);
    expect_out(4'h7, 10'h064);
    observe();
    cmd_steer <= 6'h19;
    wait_cyc(5);
    expect_out(4'h7, 10'h000);
    observe();
    // Neutral strength in torque mode, none in speed mode
    wait_cyc(3);
    expect_out(4'h3, 10'h050);
    observe();
    speed_mode <= 1'b1;
    wait_cyc(3);
    expect_out(4'h3, 10'h000);
    observe();
    speed_mode <= 1'b0;
    // Pump stays on for three ticks after the trigger drops
    cmd_sw <= 5'h04;
    wait_cyc(5);
    cmd_sw <= 5'h00;
    wait_cyc(28);
    expect_out(4'h8, 10'h001);
    observe();
    wait_cyc(45);
    expect_out(4'h8, 10'h000);
    observe();
    // Pulsing releases the park brake within a tick
    cmd_sw <= 5'h02;
    wait_cyc(43);
    expect_out(4'h9, 10'h000);
    observe();
    // Standstill applies it only after the two-tick delay
    cmd_sw <= 5'h01;
    wait_cyc(6);
    expect_out(4'h9, 10'h000);
    observe();
    wait_cyc(60);
    expect_out(4'h9, 10'h001);
    observe();
    // Pedal ramp in speed mode, then hill hold at full ramp
    cmd_pedal <= 6'h2D;
    speed_mode <= 1'b1;
    wait_cyc(6);
    expect_out(4'hA, 10'h000);
    expect_out(4'hC, 10'h001);
    observe();
    wait_cyc(45);
    expect_out(4'hA, 10'h001);
    expect_out(4'hB, 10'h0FF);
    expect_out(4'hC, 10'h000);
    observe();
    // Slow reversal in torque mode brakes at direction strength
    speed_mode <= 1'b0;
    cmd_pedal <= 6'h05;
    stator_freq <= 12'h020;
    cmd_sw <= 5'h10;
    wait_cyc(5);
    cmd_sw <= 5'h08;
    wait_cyc(5);
    expect_out(4'h3, 10'h028);
    observe();
    end_of_test();
  end
endmodule : test_traction_brake
